//--- core/snsal_pkg.sv
// sensor alarm status: shared constants, register map and carrier types
// assumes a 32-bit apb slave with word-aligned registers
package snsal_pkg;

    // converter reading width and channel order
    localparam int RDG_W = 8;
    localparam int NUM_CH = 3;
    localparam int CH_PIN0 = 0;
    localparam int CH_PIN1 = 1;
    localparam int CH_TEMP = 2;

    // captured extremes are three bits wide
    localparam int FLD_W = 3;

    // register indices as printed; byte address is four times the index
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_FLAGS = 8'h57;
    localparam logic [7:0] IDX_EXTREMES = 8'h58;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = {2'b00, IDX_FLAGS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_EXTREMES = {2'b00, IDX_EXTREMES, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 12'h170;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h174;

    // alarm flag layout: channel c owns bits 2c+1 (over) and 2c (under)
    localparam int NUM_FLAGS = 2 * NUM_CH;
    localparam int FLAG_TEMP_OVER = 5;
    localparam int FLAG_TEMP_UNDER = 4;
    localparam int FLAG_PIN1_OVER = 3;
    localparam int FLAG_PIN1_UNDER = 2;
    localparam int FLAG_PIN0_OVER = 1;
    localparam int FLAG_PIN0_UNDER = 0;

    // extremes register layout
    localparam int PEAK_LSB = 4;
    localparam int TROUGH_LSB = 0;
    localparam int SPARE_HI_BIT = 7;
    localparam int SPARE_LO_BIT = 3;

    // reset values
    localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 6'h00;
    localparam logic [FLD_W-1:0] PEAK_RESET = 3'h0;
    localparam logic [FLD_W-1:0] TROUGH_RESET = 3'h7;
    localparam logic [NUM_FLAGS-1:0] MASK_RESET = 6'h00;

    // programmed limits of one channel
    typedef struct packed {
        logic [RDG_W-1:0] upper;
        logic [RDG_W-1:0] lower;
    } snsal_lim_s;

    // one compare result, registered
    typedef struct packed {
        logic over;
        logic under;
        logic [FLD_W-1:0] code;
    } snsal_hit_s;

endpackage : snsal_pkg

//--- core/snsal_cmp.sv
// sensor alarm status: window comparator for one converter channel
// assumes reading and valid come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module snsal_cmp (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // converter sample
    input wire logic [snsal_pkg::RDG_W-1:0] reading,
    input wire logic readingValid,
    // programmed limits
    input wire snsal_pkg::snsal_lim_s limits,
    // one-cycle result, one clock after the sample
    output snsal_pkg::snsal_hit_s hit
);
    snsal_pkg::snsal_hit_s next_hit;

    always_comb begin
        next_hit.over = readingValid && (reading > limits.upper);
        next_hit.under = readingValid && (reading < limits.lower);
        // the three-bit extreme keeps only the most significant bits
        next_hit.code = reading[snsal_pkg::RDG_W-1 -: snsal_pkg::FLD_W];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hit <= '0;
        end else begin
            hit <= next_hit;
        end
    end
endmodule : snsal_cmp
`default_nettype wire

//--- core/sensor_alarm_status.sv
// sensor alarm status: clear-on-read alarm flags, first-pin extremes, apb slave and interrupt
// assumes readings, valids and limits arrive from logic on clk; apb master on clk
//
// Contract
// - temperature above upper threshold sets flag bit 5; read clears it
// - temperature below lower threshold sets flag bit 4; read clears it
// - second pin above upper threshold sets flag bit 3; read clears it
// - second pin below lower threshold sets flag bit 2; read clears it
// - first pin above upper threshold sets flag bit 1; read clears it
// - first pin below lower threshold sets flag bit 0; read clears it
// - bits 6:4 hold highest first-pin reading while over; reset and read give 0
// - bits 2:0 hold lowest first-pin reading while under; reset and read give 7
`timescale 1ns/100ps
`default_nettype none
module sensor_alarm_status (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [snsal_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter readings, index by channel (pin0, pin1, temperature)
    input wire logic [snsal_pkg::NUM_CH-1:0][snsal_pkg::RDG_W-1:0] reading,
    input wire logic [snsal_pkg::NUM_CH-1:0] readingValid,
    // programmed limits per channel
    input wire snsal_pkg::snsal_lim_s [snsal_pkg::NUM_CH-1:0] limits,
    // interrupt
    output logic irq
);

    // compare results
    snsal_pkg::snsal_hit_s [snsal_pkg::NUM_CH-1:0] hit;
    logic [snsal_pkg::NUM_FLAGS-1:0] alarmEvt;

    // register state
    logic [snsal_pkg::NUM_FLAGS-1:0] flags;
    logic [snsal_pkg::FLD_W-1:0] peak;
    logic [snsal_pkg::FLD_W-1:0] trough;
    logic spareHi;
    logic spareLo;
    logic [snsal_pkg::NUM_FLAGS-1:0] irqStatus;
    logic [snsal_pkg::NUM_FLAGS-1:0] irqMask;

    // bus decode
    logic setupPhase;
    logic accessDone;
    logic rdDone;
    logic wrDone;
    logic mapped;
    logic [31:0] readMux;

    // next values
    logic [snsal_pkg::NUM_FLAGS-1:0] next_flags;
    logic [snsal_pkg::FLD_W-1:0] next_peak;
    logic [snsal_pkg::FLD_W-1:0] next_trough;

    // one comparator per channel; channel c maps onto flag bits 2c+1 and 2c
    for (genvar c = 0; c < snsal_pkg::NUM_CH; c++) begin : g_ch
        snsal_cmp u_cmp (
            .clk(clk),
            .rstn(rstn),
            .reading(reading[c]),
            .readingValid(readingValid[c]),
            .limits(limits[c]),
            .hit(hit[c])
        );
        assign alarmEvt[2*c+1] = hit[c].over;
        assign alarmEvt[2*c] = hit[c].under;
    end

    // zero-wait slave: read data is latched in the setup cycle and shown in access
    assign pready = 1'b1;
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable;
    assign rdDone = accessDone && !pwrite;
    assign wrDone = accessDone && pwrite;

    always_comb begin
        mapped = 1'b1;
        readMux = '0;
        unique case (paddr)
            snsal_pkg::ADDR_FLAGS: begin
                readMux[snsal_pkg::NUM_FLAGS-1:0] = flags;
            end
            snsal_pkg::ADDR_EXTREMES: begin
                readMux[snsal_pkg::SPARE_HI_BIT] = spareHi;
                readMux[snsal_pkg::PEAK_LSB +: snsal_pkg::FLD_W] = peak;
                readMux[snsal_pkg::SPARE_LO_BIT] = spareLo;
                readMux[snsal_pkg::TROUGH_LSB +: snsal_pkg::FLD_W] = trough;
            end
            snsal_pkg::ADDR_IRQ_STATUS: begin
                readMux[snsal_pkg::NUM_FLAGS-1:0] = irqStatus;
            end
            snsal_pkg::ADDR_IRQ_MASK: begin
                readMux[snsal_pkg::NUM_FLAGS-1:0] = irqMask;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            prdata <= pwrite ? 32'h0000_0000 : readMux;
            pslverr <= !mapped;
        end
    end

    // clear-on-read acts only on bits that the master actually saw in prdata,
    // so an alarm raised between setup and access is never dropped
    always_comb begin
        next_flags = flags;
        if (rdDone && paddr == snsal_pkg::ADDR_FLAGS) begin
            next_flags = flags & ~prdata[snsal_pkg::NUM_FLAGS-1:0];
        end
        next_flags = next_flags | alarmEvt;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags <= snsal_pkg::FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // first-pin extremes; a read restores the idle code only if the field
    // still holds the value that was shown, and a fresh capture wins
    always_comb begin
        next_peak = peak;
        next_trough = trough;
        if (rdDone && paddr == snsal_pkg::ADDR_EXTREMES) begin
            if (peak == prdata[snsal_pkg::PEAK_LSB +: snsal_pkg::FLD_W]) begin
                next_peak = snsal_pkg::PEAK_RESET;
            end
            if (trough == prdata[snsal_pkg::TROUGH_LSB +: snsal_pkg::FLD_W]) begin
                next_trough = snsal_pkg::TROUGH_RESET;
            end
        end
        if (hit[snsal_pkg::CH_PIN0].over && hit[snsal_pkg::CH_PIN0].code > next_peak) begin
            next_peak = hit[snsal_pkg::CH_PIN0].code;
        end
        if (hit[snsal_pkg::CH_PIN0].under && hit[snsal_pkg::CH_PIN0].code < next_trough) begin
            next_trough = hit[snsal_pkg::CH_PIN0].code;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            peak <= snsal_pkg::PEAK_RESET;
            trough <= snsal_pkg::TROUGH_RESET;
        end else begin
            peak <= next_peak;
            trough <= next_trough;
        end
    end

    // spare bits of the extremes register are plain storage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            spareHi <= 1'b0;
            spareLo <= 1'b0;
        end else if (wrDone && paddr == snsal_pkg::ADDR_EXTREMES) begin
            spareHi <= pwdata[snsal_pkg::SPARE_HI_BIT];
            spareLo <= pwdata[snsal_pkg::SPARE_LO_BIT];
        end
    end

    // interrupt: sticky copy of every alarm, write one to clear, set beats clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqStatus <= '0;
        end else if (wrDone && paddr == snsal_pkg::ADDR_IRQ_STATUS) begin
            irqStatus <= (irqStatus & ~pwdata[snsal_pkg::NUM_FLAGS-1:0]) | alarmEvt;
        end else begin
            irqStatus <= irqStatus | alarmEvt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqMask <= snsal_pkg::MASK_RESET;
        end else if (wrDone && paddr == snsal_pkg::ADDR_IRQ_MASK) begin
            irqMask <= pwdata[snsal_pkg::NUM_FLAGS-1:0];
        end
    end

    // mask bit high lets the matching status bit through
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus & irqMask);
        end
    end

endmodule : sensor_alarm_status
`default_nettype wire

//--- testbench/snsal_properties.sv
// port checker for the sensor alarm status block
// bound below to every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module snsal_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [snsal_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // sensors
    input wire logic [snsal_pkg::NUM_CH-1:0][snsal_pkg::RDG_W-1:0] reading,
    input wire logic [snsal_pkg::NUM_CH-1:0] readingValid,
    input wire snsal_pkg::snsal_lim_s [snsal_pkg::NUM_CH-1:0] limits
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic rdF;
    logic rdX;
    logic bad;
    assign rdF = psel && !penable && !pwrite && paddr == snsal_pkg::ADDR_FLAGS;
    assign rdX = psel && !penable && !pwrite && paddr == snsal_pkg::ADDR_EXTREMES;
    assign bad = psel && !penable && !(paddr inside {snsal_pkg::ADDR_FLAGS,
        snsal_pkg::ADDR_EXTREMES, snsal_pkg::ADDR_IRQ_STATUS, snsal_pkg::ADDR_IRQ_MASK});
    AST_READY: assert property (pready) else $error("pready low");
    AST_UNMAPPED: assert property (bad |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_STANDS: assert property (psel && penable |=> $stable(prdata) && $stable(pslverr))
        else $error("read data moved after access");
    AST_FLAGS_TOP: assert property (rdF |=> prdata[31:6] == 26'h0) else $error("flag bits high");
    AST_TEMP_OVER: assert property (
        (readingValid[2] && reading[2] > limits[2].upper) ##[3:5] rdF |=> prdata[5])
        else $error("temperature over flag missing");
    AST_PIN1_UNDER: assert property (
        (readingValid[1] && reading[1] < limits[1].lower) ##[3:5] rdF |=> prdata[2])
        else $error("second pin under flag missing");
    AST_PIN0_OVER: assert property (
        (readingValid[0] && reading[0] > limits[0].upper) ##[3:5] rdF |=> prdata[1])
        else $error("first pin over flag missing");
    AST_PEAK: assert property (
        (readingValid[0] && reading[0] > limits[0].upper && reading[0][7:5] != 3'h0)
        ##[3:8] rdX |=> prdata[6:4] != 3'h0) else $error("peak not captured");
    AST_TROUGH: assert property (
        (readingValid[0] && reading[0] < limits[0].lower && reading[0][7:5] != 3'h7)
        ##[3:8] rdX |=> prdata[2:0] != 3'h7) else $error("trough not captured");
endmodule : snsal_checker
bind sensor_alarm_status snsal_checker i_chk (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reading(reading), .readingValid(readingValid), .limits(limits));
`default_nettype wire

//--- testbench/sensor_alarm_status_tb.sv
// self-checking bench for the sensor alarm status block
// drives apb and converter samples itself; limits fixed at c0 and 40
`timescale 1ns/100ps
`default_nettype none
module sensor_alarm_status_tb;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, err, hi;
    logic [snsal_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [snsal_pkg::NUM_CH-1:0][snsal_pkg::RDG_W-1:0] reading;
    logic [snsal_pkg::NUM_CH-1:0] readingValid;
    snsal_pkg::snsal_lim_s [snsal_pkg::NUM_CH-1:0] limits;
    logic [7:0] v;
    int nErrors = 0;
    int samplesChecked = 0;
    int cyc = 0;
    int ch;

    sensor_alarm_status i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reading(reading), .readingValid(readingValid),
        .limits(limits), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // entered just after an edge; leaves one idle edge so psel is never reassigned
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk

    task automatic samp(input int c, input logic [7:0] val);
        reading[c] <= val;
        readingValid[c] <= 1'b1;
        @(posedge clk);
        readingValid[c] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : samp

    function automatic logic [31:0] ext(input logic [2:0] pk, input logic [2:0] tr);
        return {24'h0, 1'b0, pk, 1'b0, tr};
    endfunction : ext

    task automatic completeRun();
        $display("checks %0d errors %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : completeRun

    // the whole sequence needs well under 2000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            nErrors++;
            completeRun();
        end
    end

    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata, reading, readingValid} = '0;
        limits = {3{snsal_pkg::snsal_lim_s'{upper: 8'hc0, lower: 8'h40}}};
        void'($urandom(32'hfda8));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdchk(snsal_pkg::ADDR_FLAGS, 32'h0);
        rdchk(snsal_pkg::ADDR_EXTREMES, ext(3'h0, 3'h7));
        apb(1'b0, 12'h0f0, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, snsal_pkg::ADDR_FLAGS, 32'h3f);
        samp(2, 8'hc0);
        samp(2, 8'h40);
        rdchk(snsal_pkg::ADDR_FLAGS, 32'h0);
        for (int i = 0; i < 12; i++) begin
            ch = i % 3;
            hi = i[1] ^ i[2];
            samp(ch, 8'h40 + 8'($urandom % 129));
            v = hi ? 8'hc1 + 8'($urandom % 63) : 8'($urandom % 64);
            samp(ch, v);
            rdchk(snsal_pkg::ADDR_FLAGS, 32'h1 << (2 * ch + hi));
            if (ch == 0)
                rdchk(snsal_pkg::ADDR_EXTREMES, hi ? ext(v[7:5], 3'h7) : ext(3'h0, v[7:5]));
            rdchk(snsal_pkg::ADDR_FLAGS, 32'h0);
        end
        rdchk(snsal_pkg::ADDR_EXTREMES, ext(3'h0, 3'h7));
        apb(1'b1, snsal_pkg::ADDR_EXTREMES, 32'h88);
        rdchk(snsal_pkg::ADDR_EXTREMES, 32'h8f);
        apb(1'b1, snsal_pkg::ADDR_IRQ_STATUS, 32'h3f);
        apb(1'b1, snsal_pkg::ADDR_IRQ_MASK, 32'h20);
        samp(0, 8'h00);
        check({31'h0, irq}, 32'h0);
        samp(2, 8'hff);
        @(posedge clk);
        check({31'h0, irq}, 32'h1);
        rdchk(snsal_pkg::ADDR_IRQ_STATUS, 32'h21);
        apb(1'b1, snsal_pkg::ADDR_IRQ_STATUS, 32'h20);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rdchk(snsal_pkg::ADDR_FLAGS, 32'h21);
        reading[2] <= 8'hff;
        readingValid[2] <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(snsal_pkg::ADDR_FLAGS, 32'h20);
        rdchk(snsal_pkg::ADDR_FLAGS, 32'h20);
        completeRun();
    end
endmodule : sensor_alarm_status_tb
`default_nettype wire
